/* tb/rsx_exec_assertions.sv */
// rsx_exec_assertions: result values and timing of the execution port.
// assumes it is bound to rsx_exec and sees only its ports.
`timescale 1ns/100ps
module rsx_exec_assertions import rsx_pkg::*; #(
	parameter int CNT_W = RSX_CNT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// execution port
	input wire rsx_req_t req,
	input wire logic [RSX_DATA_W-1:0] acc_in,
	input wire logic [RSX_DATA_W-1:0] mem_in,
	input wire rsx_flags_t flags_in,
	input wire logic ready,
	input wire rsx_res_t res
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic tk;
	rsx_op_t op;
	assign tk = req.valid && ready;
	assign op = req.op;
	a_rotl_acc: assert property (tk && op == RSX_OP_ROTATE_LEFT_TO_ACC |=> res.done
		&& res.acc_we && res.acc == {$past(mem_in[6:0]), $past(mem_in[7])} && !res.flags_we)
		else $error("rotate left to acc wrong");
	a_rotl_link_mem: assert property (tk && op == RSX_OP_ROTATE_LEFT_THRU_LINK_MEM |=> res.mem_we
		&& res.mem == {$past(mem_in[6:0]), $past(flags_in.carry)}
		&& res.flags.carry == $past(mem_in[7])) else $error("left through carry wrong");
	a_rotr_mem: assert property (tk && op == RSX_OP_ROTATE_RIGHT_MEM |=> res.mem_we
		&& !res.acc_we && res.mem == {$past(mem_in[0]), $past(mem_in[7:1])} && !res.flags_we)
		else $error("rotate right to memory wrong");
	a_borrow_acc: assert property (tk && op == RSX_OP_MINUS_WITH_BORROW_ACC
		&& !req.use_imm |=> res.acc == $past(acc_in) - $past(mem_in) - {7'h00, !$past(flags_in.carry)})
		else $error("borrow subtract wrong");
	a_skip_bit: assert property (tk && op == RSX_OP_SKIP_BIT_NONZERO |=> !res.mem_we
		&& res.skip == $past(mem_in[req.bit_sel])) else $error("bit skip wrong");
	a_rotr_link_acc: assert property (tk && op == RSX_OP_ROTATE_RIGHT_THRU_LINK_ACC |=> !res.mem_we
		&& res.acc == {$past(flags_in.carry), $past(mem_in[7:1])}
		&& res.flags.carry == $past(mem_in[0])) else $error("right through carry wrong");
	a_sub_carry: assert property (tk && op == RSX_OP_MINUS_TO_ACC && !req.use_imm |=>
		res.acc == $past(acc_in) - $past(mem_in)
		&& res.flags.carry == ($past(acc_in) >= $past(mem_in))) else $error("subtract wrong");
	a_dec_skip: assert property (tk && op == RSX_OP_DECREMENT_SKIP_ZERO |=>
		res.mem == $past(mem_in) - 8'h01 && res.skip == ($past(mem_in) == 8'h01))
		else $error("decrement skip wrong");
	a_skip_dummy: assert property (res.skip |-> !ready)
		else $error("no dummy cycle after skip");
	a_set_byte: assert property (tk && op == RSX_OP_SET_BYTE |=> res.mem_we
		&& res.mem == RSX_BYTE_ONES && !res.flags_we) else $error("byte set wrong");
	a_set_bit: assert property (tk && op == RSX_OP_SET_BIT |=>
		res.mem == ($past(mem_in) | (8'h01 << $past(req.bit_sel)))) else $error("bit set wrong");
endmodule

bind rsx_exec rsx_exec_assertions #(.CNT_W(CNT_W)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
	.req(req), .acc_in(acc_in), .mem_in(mem_in), .flags_in(flags_in), .ready(ready), .res(res));

/* tb/testbench.sv */
// testbench: directed operations, skips and register accesses on rsx_exec.
// assumes the checker file is compiled beside it.
`timescale 1ns/100ps
module testbench import rsx_pkg::*;;
	localparam rsx_flags_t fn = RSX_FLAGS_NONE;
	localparam rsx_flags_t fc = RSX_FLAGS_CARRY;
	localparam rsx_flags_t fa = RSX_FLAGS_ALL;
	logic ref_clk;
	logic nrst;
	rsx_req_t req;
	logic [7:0] acc_in;
	logic [7:0] mem_in;
	rsx_flags_t flags_in;
	logic ready;
	rsx_res_t res;
	rsx_bus_t bus;
	logic [31:0] bus_rdata;
	int bad_count;
	int comparisons;

	rsx_exec #(.CNT_W(16)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .req(req), .acc_in(acc_in),
		.mem_in(mem_in), .flags_in(flags_in), .ready(ready), .res(res), .bus(bus),
		.bus_rdata(bus_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// dst 0 acc, 1 memory, 2 no write; the memory byte doubles as immediate
	task automatic t(input rsx_op_t op, input logic u, input logic [2:0] bs, input logic [7:0] a,
		input logic [7:0] m, input logic c, input int dst, input logic [7:0] v,
		input rsx_flags_t fw, input logic ec, input logic sk);
		@(posedge ref_clk);
		req <= '{1'b1, op, u, bs, m};
		acc_in <= a;
		mem_in <= m;
		flags_in <= c ? fc : fn;
		@(posedge ref_clk);
		req.valid <= 1'b0;
		#1;
		check({res.done, res.skip, res.acc_we, res.mem_we, ready},
			{1'b1, sk, dst == 0, dst == 1, !sk});
		if (dst < 2) check(dst == 1 ? res.mem : res.acc, v);
		check(res.flags_we, fw);
		if (fw[3]) check(res.flags.carry, ec);
	endtask

	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{ad, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] ad, input logic [31:0] mk, input logic [31:0] e);
		@(posedge ref_clk);
		bus <= '{ad, 32'h0, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		check(bus_rdata & mk, e);
	endtask

	// generous: the tests need well under 300 cycles
	initial begin
		repeat (3000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		req = '0;
		acc_in = 8'h00;
		mem_in = 8'h00;
		flags_in = fn;
		bus = '0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		t(RSX_OP_ROTATE_LEFT_TO_ACC, 0, 0, 8'h00, 8'h81, 1, 0, 8'h03, fn, 0, 0);
		t(RSX_OP_ROTATE_LEFT_THRU_LINK_MEM, 0, 0, 8'h00, 8'h80, 0, 1, 8'h00, fc, 1, 0);
		t(RSX_OP_ROTATE_LEFT_THRU_LINK_ACC, 0, 0, 8'h00, 8'h01, 1, 0, 8'h03, fc, 0, 0);
		t(RSX_OP_ROTATE_RIGHT_MEM, 0, 0, 8'h00, 8'h01, 0, 1, 8'h80, fn, 0, 0);
		t(RSX_OP_ROTATE_RIGHT_TO_ACC, 0, 0, 8'h00, 8'h02, 0, 0, 8'h01, fn, 0, 0);
		t(RSX_OP_ROTATE_RIGHT_THRU_LINK_MEM, 0, 0, 8'h00, 8'h01, 0, 1, 8'h00, fc, 1, 0);
		t(RSX_OP_ROTATE_RIGHT_THRU_LINK_ACC, 0, 0, 8'h00, 8'h02, 1, 0, 8'h81, fc, 0, 0);
		$display("rotate test done");
		t(RSX_OP_MINUS_WITH_BORROW_ACC, 0, 0, 8'h10, 8'h05, 0, 0, 8'h0a, fa, 1, 0);
		check(res.flags, 6'h08);
		t(RSX_OP_MINUS_WITH_BORROW_ACC, 0, 0, 8'h05, 8'h05, 1, 0, 8'h00, fa, 1, 0);
		check(res.flags, 6'h0e);
		t(RSX_OP_MINUS_WITH_BORROW_ACC, 1, 0, 8'h10, 8'h20, 1, 0, 8'hf0, fa, 0, 0);
		t(RSX_OP_MINUS_WITH_BORROW_MEM, 0, 0, 8'h05, 8'h05, 0, 1, 8'hff, fa, 0, 0);
		t(RSX_OP_MINUS_TO_ACC, 0, 0, 8'h03, 8'h03, 0, 0, 8'h00, fa, 1, 0);
		check(res.flags, 6'h2e);
		t(RSX_OP_MINUS_TO_MEM, 0, 0, 8'h00, 8'h01, 1, 1, 8'hff, fa, 0, 0);
		t(RSX_OP_MINUS_TO_ACC, 1, 0, 8'h80, 8'h7f, 0, 0, 8'h01, fa, 1, 0);
		check(res.flags, 6'h19);
		$display("subtract test done");
		t(RSX_OP_DECREMENT_SKIP_ZERO, 0, 0, 8'h00, 8'h01, 0, 1, 8'h00, fn, 0, 1);
		t(RSX_OP_DECREMENT_SKIP_ZERO, 0, 0, 8'h00, 8'h02, 0, 1, 8'h01, fn, 0, 0);
		t(RSX_OP_DECREMENT_SKIP_ZERO_ACC, 0, 0, 8'h00, 8'h01, 0, 0, 8'h00, fn, 0, 1);
		t(RSX_OP_INCREMENT_SKIP_ZERO, 0, 0, 8'h00, 8'hff, 0, 1, 8'h00, fn, 0, 1);
		t(RSX_OP_INCREMENT_SKIP_ZERO, 0, 0, 8'h00, 8'h00, 0, 1, 8'h01, fn, 0, 0);
		t(RSX_OP_INCREMENT_SKIP_ZERO_ACC, 0, 0, 8'h00, 8'hff, 0, 0, 8'h00, fn, 0, 1);
		t(RSX_OP_SKIP_BIT_NONZERO, 0, 4, 8'h00, 8'h10, 0, 2, 8'h00, fn, 0, 1);
		t(RSX_OP_SKIP_BIT_NONZERO, 0, 4, 8'h00, 8'hef, 0, 2, 8'h00, fn, 0, 0);
		t(RSX_OP_SKIP_NONZERO, 0, 0, 8'h00, 8'h05, 0, 1, 8'h05, fn, 0, 1);
		t(RSX_OP_SKIP_NONZERO, 0, 0, 8'h00, 8'h00, 0, 1, 8'h00, fn, 0, 0);
		t(RSX_OP_SET_BYTE, 0, 0, 8'h00, 8'h5a, 0, 1, 8'hff, fn, 0, 0);
		t(RSX_OP_SET_BIT, 0, 3, 8'h00, 8'h00, 0, 1, 8'h08, fn, 0, 0);
		t(RSX_OP_SET_BIT, 0, 7, 8'h00, 8'h01, 0, 1, 8'h81, fn, 0, 0);
		$display("skip and set test done");
		// six skips above; a clear written with enable kept high restarts the count
		rd(RSX_REG_SKIPS, 32'hffffffff, 32'h6);
		rd(RSX_REG_LAST, 32'hffffffff, 32'h81);
		rd(RSX_REG_STAT, 32'hff, 32'h80);
		rd(4'h2, 32'hffffffff, 32'h0);
		wr(RSX_REG_CTRL, 32'h3);
		rd(RSX_REG_SKIPS, 32'hffffffff, 32'h0);
		rd(RSX_REG_CTRL, 32'hffffffff, 32'h1);
		// while disabled a request must be ignored without any result
		wr(RSX_REG_CTRL, 32'h0);
		@(posedge ref_clk);
		req.valid <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check({res.done, ready}, 2'b00);
		@(posedge ref_clk);
		req.valid <= 1'b0;
		wr(RSX_REG_CTRL, 32'h1);
		$display("register test done");
		print_verdict();
	end
endmodule

/* verilog/rsx_exec.sv */
// rsx_exec: execution datapath for rotates, subtracts, skips and byte/bit set.
// assumes the decoder holds acc, memory byte and flags stable beside each request
// and applies the registered write-backs in the cycle that done is high.
//
// Overview of operation
// - rotate left into acc, memory and flags kept
// - left through carry, write memory, carry=old bit7
// - left through carry into acc, carry=bit7
// - rotate right to memory, bit0 into bit7
// - rotate right into acc, flags untouched
// - right through carry, carry=old bit0
// - acc minus operand minus inverted carry to acc
// - borrow subtract result written back to memory
// - carry clear if negative, else set
// - subtracts update all six arithmetic flags
// - plain memory subtract to acc or memory
// - plain immediate subtract into acc
// - decrement memory, skip when zero
// - decrement into acc, skip when zero
// - increment memory, skip when zero
// - increment into acc, skip when zero
// - skip when selected bit is set
// - rewrite byte unchanged, skip when nonzero
// - byte set writes all ones, no flags
// - bit set forces one bit only
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module rsx_exec import rsx_pkg::*; #(
	parameter int CNT_W = RSX_CNT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// decoded request and operands
	input wire rsx_req_t req,
	input wire logic [RSX_DATA_W-1:0] acc_in,
	input wire logic [RSX_DATA_W-1:0] mem_in,
	input wire rsx_flags_t flags_in,
	output logic ready,
	// write-backs and skip
	output rsx_res_t res,
	// register port
	input wire rsx_bus_t bus,
	output logic [31:0] bus_rdata
);

	// the skip count is read back inside one 32-bit word
	if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
		$error("rsx_exec: CNT_W must lie in 1..32");
	end
	// rotations, masks and flag taps are written for a byte-wide datapath only
	if (RSX_DATA_W != 8) begin : g_bad_data_w
		$error("rsx_exec: the datapath serves 8-bit data only");
	end

	typedef struct packed {
		rsx_state_t st;
		logic ready;
		logic enable;
		rsx_res_t res;
		logic [CNT_W-1:0] skips;
		logic [RSX_DATA_W-1:0] last;
		logic [31:0] rdata;
	} rsx_regs_t;

	rsx_regs_t s_q;
	rsx_regs_t s_d;

	// zero test shared by the subtract flags, the counting skips and the byte test
	function automatic logic is_zero(input logic [7:0] v);
		return (v == RSX_BYTE_ZERO);
	endfunction

	// subtraction with flags; borrow_in is one when a borrow is to be taken
	typedef struct packed {
		logic [RSX_DATA_W-1:0] r;
		rsx_flags_t f;
	} rsx_sub_t;

	function automatic rsx_sub_t sub8(input logic [7:0] a, input logic [7:0] b,
			input logic borrow_in, input logic chain, input logic null_prev);
		logic [8:0] full;
		logic [4:0] low;
		rsx_sub_t o;
		full = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
		o.r = full[7:0];
		o.f.carry = ~full[8];
		o.f.nibble_carry_flag = ~low[4];
		o.f.signed_wrap_flag = (a[7] ^ b[7]) & (a[7] ^ full[7]);
		o.f.zero = is_zero(full[7:0]);
		o.f.signed_compare_flag = o.f.signed_wrap_flag ^ full[7];
		// chained zero keeps earlier nonzero bytes of a multi-byte borrow chain
		o.f.chained_null_flag = chain ? (o.f.zero & null_prev) : o.f.zero;
		return o;
	endfunction

	// set bit mask from the bit select, used by both bit test and bit set
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		return RSX_BYTE_ONE << sel;
	endfunction

	// one-bit rotations; fill is the bit entering the vacated end, which is the
	// wrapped bit for a plain rotate and the carry for a rotate through it
	function automatic logic [7:0] rot_left(input logic [7:0] v, input logic fill);
		return {v[6:0], fill};
	endfunction

	function automatic logic [7:0] rot_right(input logic [7:0] v, input logic fill);
		return {fill, v[7:1]};
	endfunction

	logic take;
	logic [7:0] operand;
	logic [7:0] dec_v;
	logic [7:0] inc_v;
	logic do_skip;
	rsx_sub_t sub_r;
	rsx_res_t nres;

	assign take = req.valid & s_q.ready;
	assign operand = req.use_imm ? req.imm : mem_in;

	always_comb begin
		dec_v = mem_in - RSX_BYTE_ONE;
		inc_v = mem_in + RSX_BYTE_ONE;
		do_skip = 1'b0;
		sub_r = sub8(acc_in, operand, 1'b0, 1'b0, flags_in.chained_null_flag);
		nres = '0;
		nres.flags = flags_in;
		nres.done = 1'b1;
		unique case (req.op)
			RSX_OP_NOP: begin
				nres.flags = flags_in;
			end
			RSX_OP_ROTATE_LEFT_TO_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = rot_left(mem_in, mem_in[7]);
			end
			RSX_OP_ROTATE_LEFT_THRU_LINK_MEM: begin
				nres.mem_we = 1'b1;
				nres.mem = rot_left(mem_in, flags_in.carry);
				nres.flags_we = RSX_FLAGS_CARRY;
				nres.flags.carry = mem_in[7];
			end
			RSX_OP_ROTATE_LEFT_THRU_LINK_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = rot_left(mem_in, flags_in.carry);
				nres.flags_we = RSX_FLAGS_CARRY;
				nres.flags.carry = mem_in[7];
			end
			RSX_OP_ROTATE_RIGHT_MEM: begin
				nres.mem_we = 1'b1;
				nres.mem = rot_right(mem_in, mem_in[0]);
			end
			RSX_OP_ROTATE_RIGHT_TO_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = rot_right(mem_in, mem_in[0]);
			end
			RSX_OP_ROTATE_RIGHT_THRU_LINK_MEM: begin
				nres.mem_we = 1'b1;
				nres.mem = rot_right(mem_in, flags_in.carry);
				nres.flags_we = RSX_FLAGS_CARRY;
				nres.flags.carry = mem_in[0];
			end
			RSX_OP_ROTATE_RIGHT_THRU_LINK_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = rot_right(mem_in, flags_in.carry);
				nres.flags_we = RSX_FLAGS_CARRY;
				nres.flags.carry = mem_in[0];
			end
			RSX_OP_MINUS_WITH_BORROW_ACC: begin
				sub_r = sub8(acc_in, operand, ~flags_in.carry, 1'b1,
					flags_in.chained_null_flag);
				nres.acc_we = 1'b1;
				nres.acc = sub_r.r;
				nres.flags_we = RSX_FLAGS_ALL;
				nres.flags = sub_r.f;
			end
			RSX_OP_MINUS_WITH_BORROW_MEM: begin
				// immediate makes no sense for a memory write-back, so the memory byte is forced
				sub_r = sub8(acc_in, mem_in, ~flags_in.carry, 1'b1,
					flags_in.chained_null_flag);
				nres.mem_we = 1'b1;
				nres.mem = sub_r.r;
				nres.flags_we = RSX_FLAGS_ALL;
				nres.flags = sub_r.f;
			end
			RSX_OP_MINUS_TO_ACC: begin
				// operand is the memory byte or, with use_imm, the immediate
				nres.acc_we = 1'b1;
				nres.acc = sub_r.r;
				nres.flags_we = RSX_FLAGS_ALL;
				nres.flags = sub_r.f;
			end
			RSX_OP_MINUS_TO_MEM: begin
				sub_r = sub8(acc_in, mem_in, 1'b0, 1'b0, flags_in.chained_null_flag);
				nres.mem_we = 1'b1;
				nres.mem = sub_r.r;
				nres.flags_we = RSX_FLAGS_ALL;
				nres.flags = sub_r.f;
			end
			RSX_OP_DECREMENT_SKIP_ZERO: begin
				nres.mem_we = 1'b1;
				nres.mem = dec_v;
				do_skip = is_zero(dec_v);
			end
			RSX_OP_DECREMENT_SKIP_ZERO_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = dec_v;
				do_skip = is_zero(dec_v);
			end
			RSX_OP_INCREMENT_SKIP_ZERO: begin
				nres.mem_we = 1'b1;
				nres.mem = inc_v;
				do_skip = is_zero(inc_v);
			end
			RSX_OP_INCREMENT_SKIP_ZERO_ACC: begin
				nres.acc_we = 1'b1;
				nres.acc = inc_v;
				do_skip = is_zero(inc_v);
			end
			RSX_OP_SKIP_BIT_NONZERO: begin
				do_skip = |(mem_in & bit_mask(req.bit_sel));
			end
			RSX_OP_SKIP_NONZERO: begin
				// the byte is rewritten unchanged so read-sensitive locations behave alike
				nres.mem_we = 1'b1;
				nres.mem = mem_in;
				do_skip = !is_zero(mem_in);
			end
			RSX_OP_SET_BYTE: begin
				nres.mem_we = 1'b1;
				nres.mem = RSX_BYTE_ONES;
			end
			RSX_OP_SET_BIT: begin
				nres.mem_we = 1'b1;
				nres.mem = mem_in | bit_mask(req.bit_sel);
			end
			default: begin
				// undefined opcodes retire as no-ops rather than corrupt state
				nres.flags = flags_in;
			end
		endcase
		nres.skip = do_skip;
	end

	always_comb begin
		s_d = s_q;
		s_d.res = '0;
		s_d.res.flags = s_q.res.flags;
		s_d.rdata = '0;
		// register writes
		if (bus.wr) begin
			unique case (bus.addr)
				RSX_REG_CTRL: begin
					s_d.enable = bus.wdata[RSX_CTRL_EN_BIT];
					if (bus.wdata[RSX_CTRL_CLR_BIT]) begin
						s_d.skips = '0;
					end
				end
				default: begin
					s_d.enable = s_q.enable;
				end
			endcase
		end
		// register reads, answered in the next cycle only
		if (bus.rd) begin
			unique case (bus.addr)
				RSX_REG_CTRL: begin
					s_d.rdata[RSX_CTRL_EN_BIT] = s_q.enable;
				end
				RSX_REG_STAT: begin
					s_d.rdata[RSX_STAT_FLAGS_LSB +: 6] = s_q.res.flags;
					s_d.rdata[RSX_STAT_DUMMY_BIT] = (s_q.st == RSX_ST_DUMMY);
					s_d.rdata[RSX_STAT_READY_BIT] = s_q.ready;
				end
				RSX_REG_SKIPS: begin
					s_d.rdata[CNT_W-1:0] = s_q.skips;
				end
				RSX_REG_LAST: begin
					s_d.rdata[RSX_DATA_W-1:0] = s_q.last;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
		// execution; a skip parks the core for one dummy cycle
		unique case (s_q.st)
			RSX_ST_RUN: begin
				if (take) begin
					s_d.res = nres;
					s_d.last = nres.acc_we ? nres.acc : nres.mem;
					if (nres.skip) begin
						s_d.st = RSX_ST_DUMMY;
						// counted on top of a clear in the same cycle, so no skip is lost
						s_d.skips = s_d.skips + {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			RSX_ST_DUMMY: begin
				s_d.st = RSX_ST_RUN;
			end
		endcase
		s_d.ready = s_d.enable & (s_d.st == RSX_ST_RUN);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.st <= RSX_ST_RUN;
			s_q.enable <= RSX_EN_RST;
			s_q.ready <= RSX_EN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign ready = s_q.ready;
	assign res = s_q.res;
	assign bus_rdata = s_q.rdata;

endmodule

/* verilog/rsx_pkg.sv */
// rsx_pkg: types and constants shared by the rotate/subtract/skip datapath.
// assumes an 8-bit core with a separate decoder that issues one request per cycle.
package rsx_pkg;

	localparam int RSX_DATA_W = 8;
	localparam int RSX_ADDR_W = 4;
	localparam int RSX_CNT_W = 16;

	// register map, byte addresses on the plain register port
	localparam logic [RSX_ADDR_W-1:0] RSX_REG_CTRL = 4'h0;
	localparam logic [RSX_ADDR_W-1:0] RSX_REG_STAT = 4'h4;
	localparam logic [RSX_ADDR_W-1:0] RSX_REG_SKIPS = 4'h8;
	localparam logic [RSX_ADDR_W-1:0] RSX_REG_LAST = 4'hc;

	// field positions
	localparam int RSX_CTRL_EN_BIT = 0;
	localparam int RSX_CTRL_CLR_BIT = 1;
	localparam int RSX_STAT_FLAGS_LSB = 0;
	localparam int RSX_STAT_DUMMY_BIT = 6;
	localparam int RSX_STAT_READY_BIT = 7;

	// reset value and byte constants
	localparam logic RSX_EN_RST = 1'b1;
	localparam logic [7:0] RSX_BYTE_ZERO = 8'h00;
	localparam logic [7:0] RSX_BYTE_ONES = 8'hff;
	localparam logic [7:0] RSX_BYTE_ONE = 8'h01;

	// timing: an execution answers one cycle after it is taken, a skip adds one dummy cycle
	localparam int RSX_EXEC_CYCLES = 1;
	localparam int RSX_DUMMY_CYCLES = 1;

	typedef enum logic [4:0] {
		RSX_OP_NOP = 5'h00,
		RSX_OP_ROTATE_LEFT_TO_ACC = 5'h01,
		RSX_OP_ROTATE_LEFT_THRU_LINK_MEM = 5'h02,
		RSX_OP_ROTATE_LEFT_THRU_LINK_ACC = 5'h03,
		RSX_OP_ROTATE_RIGHT_MEM = 5'h04,
		RSX_OP_ROTATE_RIGHT_TO_ACC = 5'h05,
		RSX_OP_ROTATE_RIGHT_THRU_LINK_MEM = 5'h06,
		RSX_OP_ROTATE_RIGHT_THRU_LINK_ACC = 5'h07,
		RSX_OP_MINUS_WITH_BORROW_ACC = 5'h08,
		RSX_OP_MINUS_WITH_BORROW_MEM = 5'h09,
		RSX_OP_MINUS_TO_ACC = 5'h0a,
		RSX_OP_MINUS_TO_MEM = 5'h0b,
		RSX_OP_DECREMENT_SKIP_ZERO = 5'h0c,
		RSX_OP_DECREMENT_SKIP_ZERO_ACC = 5'h0d,
		RSX_OP_INCREMENT_SKIP_ZERO = 5'h0e,
		RSX_OP_INCREMENT_SKIP_ZERO_ACC = 5'h0f,
		RSX_OP_SKIP_BIT_NONZERO = 5'h10,
		RSX_OP_SKIP_NONZERO = 5'h11,
		RSX_OP_SET_BYTE = 5'h12,
		RSX_OP_SET_BIT = 5'h13
	} rsx_op_t;

	typedef enum logic [0:0] {
		RSX_ST_RUN = 1'b0,
		RSX_ST_DUMMY = 1'b1
	} rsx_state_t;

	// status flags, also the write mask layout
	typedef struct packed {
		logic chained_null_flag;
		logic signed_compare_flag;
		logic carry;
		logic nibble_carry_flag;
		logic zero;
		logic signed_wrap_flag;
	} rsx_flags_t;

	localparam rsx_flags_t RSX_FLAGS_NONE = 6'h00;
	localparam rsx_flags_t RSX_FLAGS_ALL = 6'h3f;
	localparam rsx_flags_t RSX_FLAGS_CARRY = 6'h08;

	typedef struct packed {
		logic valid;
		rsx_op_t op;
		logic use_imm;
		logic [2:0] bit_sel;
		logic [RSX_DATA_W-1:0] imm;
	} rsx_req_t;

	typedef struct packed {
		logic done;
		logic skip;
		logic acc_we;
		logic [RSX_DATA_W-1:0] acc;
		logic mem_we;
		logic [RSX_DATA_W-1:0] mem;
		rsx_flags_t flags_we;
		rsx_flags_t flags;
	} rsx_res_t;

	typedef struct packed {
		logic [RSX_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rsx_bus_t;

endpackage
